// *** logic/uart_multiport_status_shadow.sv ***
// read-only shadow words gathering four channels' status for one burst read
// assumes a simple read strobe from the host target logic on core_clk
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1 - offset 0x10 returns four 8-bit receive fill levels, channel 0 lowest, reset zero.
// R2 - offset 0x14 returns four 8-bit transmit fill levels, channel 0 lowest, reset zero.
// R3 - offset 0x18 holds four 6-bit interrupt codes at 5:0..23:18, reset 01h.
// R4 - good-data bits 27..30 need code none, rx available, timeout or tx empty.
// R5 - good-data also needs the channel receive-error indicator clear.
// R6 - good-data also needs the channel overrun indicator clear.
// R7 - bit 31 is the AND of the four good-data bits, one after reset.
// R8 - the four status words sit at consecutive offsets 10h to 1Ch.
// R9 - software reads receive levels before the interrupt source word.
// R10 - with good-data clear, software inspects the code; level 4+ needs normal handling.
// R11 - on receiver-status code, software reads line status then flushes the FIFO.
// R12 - fields track live channel state; reads have no side effect on channels.
module uart_multiport_status_shadow
    import shadow_status_pkg::*;
#(
    parameter int NUM_CHANNELS = 4
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // live channel state, channel 0 in the low slice
    input wire logic [4*shadow_status_pkg::LEVEL_W-1:0] rx_fill_count,
    input wire logic [4*shadow_status_pkg::LEVEL_W-1:0] tx_fill_count,
    input wire logic [4*shadow_status_pkg::CODE_W-1:0] channel_irq_code,
    input wire logic [3:0] line_status_rx_error,
    input wire logic [3:0] line_status_overrun,
    // register read port
    input wire logic rd_en,
    input wire logic [shadow_status_pkg::OFFSET_W-1:0] rd_addr,
    output logic [31:0] rd_data,
    output logic rd_valid,
    output logic rd_hit
);
    import shadow_status_pkg::*;

    // the word layout is fixed by the host's view; refuse any sizing the packing cannot serve
    if (NUM_CHANNELS != CHAN_COUNT)
    begin : g_bad_count
        $error("status words are laid out for exactly four channels");
    end

    if (CHAN_COUNT * LEVEL_W != 32)
    begin : g_bad_level_width
        $error("level fields must fill one 32-bit word exactly");
    end

    if (CHAN_COUNT * CODE_W > GOOD_FLAG_LSB)
    begin : g_bad_code_width
        $error("interrupt codes would overlap the good-data flags");
    end

    if (GOOD_FLAG_LSB + CHAN_COUNT != GLOBAL_GOOD_BIT)
    begin : g_bad_good_layout
        $error("global good-data bit must sit just above the channel flags");
    end

    if (CODE_W < 4)
    begin : g_bad_code_bits
        $error("code fields too narrow for the good-data code set");
    end

    if (OFFSET_W < 8)
    begin : g_bad_offset_width
        $error("read offset too narrow to reach the status words");
    end

    // good-data starts set only if the reset code means nothing pending
    if (CODE_RESET != CODE_NONE_PENDING)
    begin : g_bad_code_reset
        $error("reset interrupt code must be the no-interrupt code");
    end

    // a burst read walks the four words in steps of one 32-bit word
    if (RX_LEVEL_WORD_OFS[1:0] != 2'b00)
    begin : g_bad_align
        $error("status words must start on a word boundary");
    end

    if (TX_LEVEL_WORD_OFS != RX_LEVEL_WORD_OFS + 8'h04) // R8
    begin : g_bad_tx_offset
        $error("transmit level word must follow the receive level word");
    end

    if (IRQ_SOURCE_WORD_OFS != TX_LEVEL_WORD_OFS + 8'h04) // R8
    begin : g_bad_irq_offset
        $error("interrupt source word must follow the transmit level word");
    end

    if (GLOBAL_IRQ_STATUS_WORD_OFS != IRQ_SOURCE_WORD_OFS + 8'h04) // R8
    begin : g_bad_gis_offset
        $error("global status slot must follow the interrupt source word");
    end

    // shadow outputs, channel 0 in the low slice
    logic [CHAN_COUNT*LEVEL_W-1:0] rx_lvl;
    logic [CHAN_COUNT*LEVEL_W-1:0] tx_lvl;
    logic [CHAN_COUNT*CODE_W-1:0] codes;
    logic [CHAN_COUNT-1:0] good;
    logic [31:0] rx_level_word;
    logic [31:0] tx_level_word;
    logic [31:0] irq_source_word;
    logic [31:0] global_irq_status_word;
    logic sel_rx;
    logic sel_tx;
    logic sel_irq;
    logic sel_gis;
    logic [31:0] word_d;
    logic hit_d;

    // one shadow per channel; reads never reach back into the channels
    for (genvar c = 0; c < CHAN_COUNT; c++)
    begin : g_chan
        channel_shadow u_shadow (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .rx_fill_count(rx_fill_count[c*LEVEL_W +: LEVEL_W]),
            .tx_fill_count(tx_fill_count[c*LEVEL_W +: LEVEL_W]),
            .channel_irq_code(channel_irq_code[c*CODE_W +: CODE_W]),
            .line_status_rx_error(line_status_rx_error[c]),
            .line_status_overrun(line_status_overrun[c]),
            .rx_level_q(rx_lvl[c*LEVEL_W +: LEVEL_W]),
            .tx_level_q(tx_lvl[c*LEVEL_W +: LEVEL_W]),
            .code_q(codes[c*CODE_W +: CODE_W]),
            .good_q(good[c])
        );
    end

    // level words pass the shadows straight through, channel 0 in the low byte
    always_comb
    begin
        rx_level_word = rx_lvl; // R1
        tx_level_word = tx_lvl; // R2
    end

    // the global status word belongs to another block; its slot reads zero here
    assign global_irq_status_word = 32'h0000_0000; // R8

    // reserved bits 26:24 read as zero
    always_comb
    begin
        irq_source_word = 32'h0000_0000;
        irq_source_word[CHAN_COUNT*CODE_W-1:0] = codes; // R3
        irq_source_word[GOOD_FLAG_LSB +: CHAN_COUNT] = good; // R4
        irq_source_word[GLOBAL_GOOD_BIT] = &good; // R7
    end

    // offset decode kept apart from the data mux; selects are one-hot by construction
    always_comb
    begin
        sel_rx = (rd_addr == RX_LEVEL_WORD_OFS); // R1 R8
        sel_tx = (rd_addr == TX_LEVEL_WORD_OFS); // R2 R8
        sel_irq = (rd_addr == IRQ_SOURCE_WORD_OFS); // R3 R8
        sel_gis = (rd_addr == GLOBAL_IRQ_STATUS_WORD_OFS); // R8
    end

    // unmapped offsets read zero and report no hit rather than aliasing a word
    always_comb
    begin
        word_d = 32'h0000_0000;
        hit_d = sel_rx || sel_tx || sel_irq || sel_gis; // R8
        if (sel_rx)
        begin
            word_d = rx_level_word; // R1
        end
        else if (sel_tx)
        begin
            word_d = tx_level_word; // R2
        end
        else if (sel_irq)
        begin
            word_d = irq_source_word; // R3
        end
        else if (sel_gis)
        begin
            word_d = global_irq_status_word; // R8
        end
    end

    // answer strobe: one pulse for every accepted read, fixed one-cycle latency
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en; // R12
        end
    end

    // hit flag travels with the strobe so the host can spot a stray offset
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rd_hit <= 1'b0;
        end
        else
        begin
            rd_hit <= rd_en && hit_d; // R8
        end
    end

    // a read only captures the shadows, so the channels never see it;
    // the data holds between reads so a slow host can still pick it up
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rd_data <= 32'h0000_0000;
        end
        else if (rd_en)
        begin
            rd_data <= word_d; // R12
        end
    end
endmodule : uart_multiport_status_shadow
`default_nettype wire

// *** pkg/shadow_status_pkg.sv ***
// constants for the multi-port status shadow words
// assumes byte offsets within the local configuration space, 32-bit words
package shadow_status_pkg;

    localparam int CHAN_COUNT = 4;
    localparam int LEVEL_W = 8;
    localparam int CODE_W = 6;
    localparam int OFFSET_W = 8;

    // word offsets
    localparam logic [7:0] RX_LEVEL_WORD_OFS = 8'h10;
    localparam logic [7:0] TX_LEVEL_WORD_OFS = 8'h14;
    localparam logic [7:0] IRQ_SOURCE_WORD_OFS = 8'h18;
    localparam logic [7:0] GLOBAL_IRQ_STATUS_WORD_OFS = 8'h1C;

    // field layout of the interrupt source word
    localparam int GOOD_FLAG_LSB = 27;
    localparam int GLOBAL_GOOD_BIT = 31;

    // reset values
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [5:0] CODE_RESET = 6'h01;
    localparam logic GOOD_RESET = 1'b1;

    // channel interrupt codes that still allow good data
    localparam logic [5:0] CODE_NONE_PENDING = 6'h01;
    localparam logic [5:0] CODE_RX_AVAILABLE = 6'h04;
    localparam logic [5:0] CODE_RX_TIMEOUT = 6'h0C;
    localparam logic [5:0] CODE_TX_HOLDING_EMPTY = 6'h02;

endpackage : shadow_status_pkg

// *** logic/channel_shadow.sv ***
// per-channel shadow of fill counts, interrupt code and good-data flag
// assumes channel inputs synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module channel_shadow
    import shadow_status_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // live channel state
    input wire logic [LEVEL_W-1:0] rx_fill_count,
    input wire logic [LEVEL_W-1:0] tx_fill_count,
    input wire logic [CODE_W-1:0] channel_irq_code,
    input wire logic line_status_rx_error,
    input wire logic line_status_overrun,
    // shadowed state
    output logic [LEVEL_W-1:0] rx_level_q,
    output logic [LEVEL_W-1:0] tx_level_q,
    output logic [CODE_W-1:0] code_q,
    output logic good_q
);
    logic code_ok;
    logic good_d;

    always_comb
    begin
        code_ok = (channel_irq_code == CODE_NONE_PENDING) ||
                  (channel_irq_code == CODE_RX_AVAILABLE) ||
                  (channel_irq_code == CODE_RX_TIMEOUT) ||
                  (channel_irq_code == CODE_TX_HOLDING_EMPTY); // R4
        good_d = code_ok && !line_status_rx_error // R5
                 && !line_status_overrun; // R6
    end

    // shadows follow the live state every cycle, nothing here feeds back
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            rx_level_q <= LEVEL_RESET;
            tx_level_q <= LEVEL_RESET;
            code_q <= CODE_RESET;
            good_q <= GOOD_RESET;
        end
        else
        begin
            rx_level_q <= rx_fill_count; // R12
            tx_level_q <= tx_fill_count;
            code_q <= channel_irq_code;
            good_q <= good_d; // R4
        end
    end
endmodule : channel_shadow
`default_nettype wire

// *** verification/shadow_status_assertions.sv ***
// checker on the status shadow read port
// assumes it is bound to the top module, one clock
`timescale 1ns/1ps
`default_nettype none
module shadow_chk
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // read port of the bound block
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_hit
);
    wire logic m = rd_addr inside {8'h10, 8'h14, 8'h18, 8'h1C};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_ans; rd_en |=> rd_valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; !rd_en |=> !rd_valid; endproperty
    a_one: assert property (p_one) else $error("extra answer");
    property p_hit; rd_en && m |=> rd_hit && rd_valid; endproperty
    a_hit: assert property (p_hit) else $error("no hit");
    property p_miss; rd_en && !m |=> !rd_hit && rd_data == 32'h0; endproperty
    a_miss: assert property (p_miss) else $error("bad miss");
    property p_and; rd_en && rd_addr == 8'h18 |=> rd_data[31] == &rd_data[30:27]; endproperty
    a_and: assert property (p_and) else $error("bad global");
    property p_rsv; rd_en && rd_addr == 8'h18 |=> rd_data[26:24] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("bad reserved");
    property p_gis; rd_en && rd_addr == 8'h1C |=> rd_data == 32'h0; endproperty
    a_gis: assert property (p_gis) else $error("bad last word");
    property p_keep; !rd_en |=> $stable(rd_data); endproperty
    a_keep: assert property (p_keep) else $error("data moved");
    // reset must clear the read port although every other property is gated by it
    property p_rst; disable iff (1'b0) !reset_n |=> !rd_valid && !rd_hit && rd_data == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("read port not cleared");
    c_hit: cover property (rd_valid && rd_hit);
    c_miss: cover property (rd_valid && !rd_hit);
    c_back: cover property (rd_en [*4]);
    c_rst: cover property ($rose(reset_n) && rd_en);
endmodule : shadow_chk
bind uart_multiport_status_shadow shadow_chk u_chk(.core_clk, .reset_n, .rd_en, .rd_addr, .rd_data,
    .rd_valid, .rd_hit);
`default_nettype wire

// *** verification/host_reader.sv ***
// host driver model: four-word burst reads upward from the given base offset
// assumes go is a one-cycle pulse given only between bursts
`timescale 1ns/1ps
`default_nettype none
module host_reader
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // burst request from the bench
    input wire logic go,
    input wire logic [7:0] base,
    // read port of the block
    output logic rd_en,
    output var logic [7:0] rd_addr = 8'h00
);
    logic [2:0] left_q = 3'h0;
    // a burst armed in the last reset cycle reads at the first edge after release;
    // address keeps stepping when idle so a stale offset is never read as live
    always @(posedge core_clk)
    begin
        left_q <= go ? 3'h4 : !reset_n ? 3'h0 : left_q - 3'(rd_en);
        rd_addr <= go ? base : rd_addr + 8'h04;
    end
    assign rd_en = left_q != 3'h0;
endmodule : host_reader
`default_nettype wire

// *** verification/uart_multiport_status_shadow_bench.sv ***
// bench: random channel state, burst reads through the host model
// assumes host_reader and the bound checker
`timescale 1ns/1ps
`default_nettype none
module uart_multiport_status_shadow_bench;
    logic core_clk = 1'b0, reset_n = 1'b0, go = 1'b0, rd_en, rd_valid, rd_hit;
    logic [31:0] rx = 32'h0, tx = 32'h0, rd_data;
    logic [23:0] cd = 24'h041041;
    logic [3:0] er = 4'h0, ov = 4'h0;
    logic [7:0] base = 8'h10, rd_addr;
    logic [5:0] pick [8] = '{6'h01, 6'h04, 6'h0C, 6'h02, 6'h06, 6'h00, 6'h10, 6'h3F};
    logic [32:0] q[$], e;
    int fail_count = 0, checks = 0;
    always #50 core_clk = ~core_clk;
    uart_multiport_status_shadow u_dut(.core_clk, .reset_n, .rx_fill_count(rx), .tx_fill_count(tx),
        .channel_irq_code(cd), .line_status_rx_error(er), .line_status_overrun(ov), .rd_en, .rd_addr,
        .rd_data, .rd_valid, .rd_hit);
    host_reader u_host(.core_clk, .reset_n, .go, .base, .rd_en, .rd_addr);
    function automatic logic [32:0] ex(input logic [7:0] a);
        logic [3:0] g;
        for (int i = 0; i < 4; i++)
            g[i] = cd[6*i+:6] inside {6'h01, 6'h04, 6'h0C, 6'h02} && !er[i] && !ov[i];
        case (a)
            8'h10: return {1'b1, rx};
            8'h14: return {1'b1, tx};
            8'h18: return {1'b1, &g, g, 3'h0, cd};
            8'h1C: return {1'b1, 32'h0};
            default: return 33'h0;
        endcase
    endfunction : ex
    task automatic burst(input logic [7:0] b, input logic r);
        logic [23:0] c;
        for (int i = 0; i < 4; i++)
            c[6*i+:6] = pick[$urandom % 8];
        @(posedge core_clk);
        {rx, tx, er, ov} <= r ? {$urandom, $urandom, 4'($urandom & $urandom), 4'($urandom & $urandom)} : 72'h0;
        cd <= r ? c : 24'h041041;
        base <= b;
        go <= 1'b1;
        @(negedge core_clk);
        for (int i = 0; i < 4; i++)
            q.push_back(ex(b + 8'(4 * i)));
        @(posedge core_clk);
        go <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : burst
    // reset with live state far from the reset values; only the first word still shows them
    task automatic rst_burst(input logic [7:0] b);
        @(posedge core_clk);
        reset_n <= 1'b0;
        {rx, tx, er, ov} <= {32'hFFFF_FFFF, 32'hFFFF_FFFF, 4'hF, 4'hF};
        cd <= 24'hFF_FFFF;
        @(posedge core_clk);
        base <= b;
        go <= 1'b1;
        @(negedge core_clk);
        q.push_back(b == 8'h18 ? {1'b1, 32'hF804_1041} : {1'b1, 32'h0000_0000});
        for (int i = 1; i < 4; i++)
            q.push_back(ex(b + 8'(4 * i)));
        @(posedge core_clk);
        reset_n <= 1'b1;
        go <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : rst_burst
    task automatic results();
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    always @(posedge core_clk)
        if (rd_valid === 1'b1)
        begin
            checks++;
            if (q.size() == 0)
            begin
                fail_count++;
                $display("wrong value rd_valid exp 0 got 1");
            end
            else
            begin
                e = q.pop_front();
                if ({rd_hit, rd_data} !== e)
                begin
                    fail_count++;
                    $display("wrong value rd_data exp %h got %h", e, {rd_hit, rd_data});
                end
            end
        end
    initial
    begin
        void'($urandom(32'hFB32DB50));
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        burst(8'h10, 1'b0);
        for (int n = 0; n < 3; n++)
            rst_burst(8'h10 + 8'(4 * n));
        for (int n = 0; n < 24; n++)
            burst(n == 7 ? 8'h20 : 8'h10, 1'b1);
        repeat (4) @(posedge core_clk);
        if (q.size() != 0)
        begin
            fail_count++;
            $display("wrong value pending_reads exp 0 got %0d", q.size());
        end
        results();
    end
    initial
    begin
        repeat (400) @(posedge core_clk);
        fail_count++;
        results();
    end
endmodule : uart_multiport_status_shadow_bench
`default_nettype wire
